// ==== rtl/bsc_consts.svh ====
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH
// ==========================================
// clock and timing
`define BSC_CLK_PERIOD_NS 4
`define BSC_REFRESH_NS 1500000
`define BSC_HALL_STEP_CYC 1536000
`define BSC_STEPS_PER_CYCLE 6
`define BSC_FRAC_CYC 13552941
`define BSC_CARRIER_MAX 9'h1FF
`define BSC_DEAD_CYC 5'h12
`define BSC_REFRESH_ON 9'h028
`define BSC_ANG_PER_SEC 8'h2B
`define BSC_DUTY_KNEE 8'hE0
`define BSC_DUTY_MAX 8'hFF
`define BSC_FG_WRAP 9'h140
`define BSC_FG_INC_24 9'h006
`define BSC_FG_INC_20 9'h005
`define BSC_FG_INC_08 9'h002
// ==========================================
// register map
`define BSC_OFS_CMD 12'h000
`define BSC_OFS_CFG 12'h004
`define BSC_OFS_STAT 12'h008
`define BSC_CMD_RST 32'h00000000
`define BSC_CFG_RST 32'h00000000
`define BSC_CMD_MASK 32'h000113FF
`define BSC_CFG_MASK 32'h001F030F
`define BSC_CMD_DUTY 7:0
`define BSC_CMD_RANGE 9:8
`define BSC_CMD_MODE_B 12
`define BSC_CMD_DIR 16
`define BSC_CFG_PULSE 3:0
`define BSC_CFG_SINE 9:8
`define BSC_CFG_LEAD 20:16
`define BSC_ST_SECTOR 2:0
`define BSC_ST_STATE 5:4
`define BSC_ST_SINE 8
`define BSC_ST_SLOW 9
`define BSC_ST_REV 10
`define BSC_ST_FRAC 11
// ==========================================
// codes
`define BSC_RNG_LOW 2'h0
`define BSC_RNG_REFRESH 2'h1
`define BSC_RNG_NORMAL 2'h2
`define BSC_RNG_TEST 2'h3
`define BSC_SINE_60A 2'h0
`define BSC_SINE_60B 2'h3
`define BSC_FG_3P 4'h0
`define BSC_FG_LEAD 4'h8
`define BSC_FG_1P 4'h9
`define BSC_SEC_BAD 3'h7
`define BSC_SEC_LAST 3'h5
`endif

// ==== rtl/bsc_pkg.sv ====
`default_nettype none
// ==========================================
// shared types
package bsc_pkg;
    typedef enum logic [1:0] {BSC_ST_IDLE = 2'b00, BSC_ST_REFRESH = 2'b01, BSC_ST_DRIVE = 2'b11} bsc_state_t;
    typedef enum logic [1:0] {BSC_PH_OFF = 2'b00, BSC_PH_LO = 2'b01, BSC_PH_HI = 2'b10} bsc_phase_t;
endpackage
`default_nettype wire

// ==== rtl/bsc_carrier.sv ====
`include "bsc_consts.svh"
`default_nettype none
// ==========================================
// free running carrier counter
module bsc_carrier (
    input wire logic pclk,
    input wire logic presetn,
    output logic [8:0] carrier_cnt
);
    import bsc_pkg::*;
    logic [8:0] cnt_nxt;
    // wrap after the last count of the period
    always_comb begin
        cnt_nxt = (carrier_cnt == `BSC_CARRIER_MAX) ? 9'h000 : carrier_cnt + 9'h001;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_cnt <= 9'h000;
        end else begin
            carrier_cnt <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/bsc_dead_time.sv ====
`include "bsc_consts.svh"
`default_nettype none
// ==========================================
// per phase gap between complementary devices
module bsc_dead_time (
    input wire logic pclk,
    input wire logic presetn,
    input wire bsc_pkg::bsc_phase_t want,
    output logic gate_hi,
    output logic gate_lo
);
    import bsc_pkg::*;
    bsc_phase_t grant_r, grant_nxt, last_r, last_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    // switch off first, then wait before the opposite side turns on
    always_comb begin
        grant_nxt = grant_r;
        last_nxt = last_r;
        cnt_nxt = (cnt_r != 5'h00) ? cnt_r - 5'h01 : cnt_r;
        if (want != grant_r) begin
            if (grant_r != BSC_PH_OFF) begin
                grant_nxt = BSC_PH_OFF;
                cnt_nxt = `BSC_DEAD_CYC - 5'h01;
            end else if (want == last_r || cnt_r == 5'h00) begin
                grant_nxt = want;
                last_nxt = want;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_r <= BSC_PH_OFF;
            last_r <= BSC_PH_OFF;
            cnt_r <= 5'h00;
            gate_hi <= 1'b0;
            gate_lo <= 1'b0;
        end else begin
            grant_r <= grant_nxt;
            last_r <= last_nxt;
            cnt_r <= cnt_nxt;
            gate_hi <= (grant_nxt == BSC_PH_HI);
            gate_lo <= (grant_nxt == BSC_PH_LO);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/bsc_top.sv ====
`include "bsc_consts.svh"
`default_nettype none
// Notes on behaviour
// - square drive below 1 Hz, sine above
// - too slow beyond six step periods
// - slow or reversed: square, zero lead
// - fast: apply lead angle setting
// - carrier period is 512 clocks
// - 18 clock dead time on each phase
// - one pulse mode follows U hall
// - three pulse mode toggles on hall edges
// - fractional pulses, suppressed below 0.68 Hz
// - pulse select step decode
// - step 8 shows commutation timing
// - mode bit selects command interpretation B
// - mode A lowest level blocks gates
// - refresh: low sides 40 clocks only
// - duty follows command, full duty at knee and above
// - square drive forces low side 40 clocks
// - from stop refresh 1.5 ms first
// - test range: zero lead, max duty, sine only when fast
// - test range resyncs every 60 degrees
// - mode B lowest level is refresh
// - sine select picks 60 or 360 resync
module bsc_top #(
    parameter logic [23:0] SLOW_LIMIT = 24'(`BSC_HALL_STEP_CYC * `BSC_STEPS_PER_CYCLE),
    parameter logic [23:0] FRAC_LIMIT = 24'(`BSC_FRAC_CYC),
    parameter logic [18:0] REFRESH_CYC = 19'(`BSC_REFRESH_NS / `BSC_CLK_PERIOD_NS)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hall_u_pos,
    input wire logic hall_u_neg,
    input wire logic hall_v_pos,
    input wire logic hall_v_neg,
    input wire logic hall_w_pos,
    input wire logic hall_w_neg,
    output logic gate_uh,
    output logic gate_ul,
    output logic gate_vh,
    output logic gate_vl,
    output logic gate_wh,
    output logic gate_wl,
    output logic rotation_pulse_out
);
    import bsc_pkg::*;

    // ==========================================
    // helpers
    function automatic logic [23:0] sat_inc(input logic [23:0] v);
        return (v == 24'hFFFFFF) ? v : v + 24'h000001;
    endfunction

    function automatic logic [2:0] hall_sector(input logic [2:0] h);
        logic [2:0] s;
        s = `BSC_SEC_BAD;
        unique case (h)
            3'b100: s = 3'h0;
            3'b110: s = 3'h1;
            3'b010: s = 3'h2;
            3'b011: s = 3'h3;
            3'b001: s = 3'h4;
            3'b101: s = 3'h5;
            default: s = `BSC_SEC_BAD;
        endcase
        return s;
    endfunction

    function automatic logic [2:0] sec_step(input logic [2:0] s, input logic up);
        if (up) begin
            return (s == `BSC_SEC_LAST) ? 3'h0 : s + 3'h1;
        end
        return (s == 3'h0) ? `BSC_SEC_LAST : s - 3'h1;
    endfunction

    // parabolic sine sample scaled by duty, result in carrier counts
    function automatic logic [8:0] sine_on(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] p;
        logic [7:0] m;
        logic [7:0] v;
        logic [15:0] q;
        p = {8'h00, 1'b0, a[6:0]} * {8'h00, 8'h80 - {1'b0, a[6:0]}};
        m = (p[15:12] != 4'h0) ? 8'hFF : p[11:4];
        v = a[7] ? 8'h80 - {1'b0, m[7:1]} : 8'h80 + {1'b0, m[7:1]};
        q = {8'h00, v} * {8'h00, d};
        return q[15:7];
    endfunction

    // ==========================================
    // hall synchronisers
    logic [5:0] hall_s1_r, hall_s2_r;
    logic [2:0] hall_prev_r;
    logic [2:0] hall;
    // two flops per pin, logic reads only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hall_s1_r <= 6'h00;
            hall_s2_r <= 6'h00;
            hall_prev_r <= 3'h0;
        end else begin
            hall_s1_r <= {hall_u_pos, hall_u_neg, hall_v_pos, hall_v_neg, hall_w_pos, hall_w_neg};
            hall_s2_r <= hall_s1_r;
            hall_prev_r <= hall;
        end
    end
    // differential pair to level
    assign hall = {hall_s2_r[5] & ~hall_s2_r[4], hall_s2_r[3] & ~hall_s2_r[2], hall_s2_r[1] & ~hall_s2_r[0]};

    // ==========================================
    // registers
    logic [31:0] cmd_r, cmd_nxt, cfg_r, cfg_nxt, prdata_nxt, stat_w;
    logic pready_nxt, pslverr_nxt;
    logic [1:0] range;
    logic [7:0] cmd_duty, lead_off;
    logic mode_b, cmd_dir;
    logic [3:0] pulse_sel;
    logic [1:0] sine_sel;
    bsc_state_t state_r, state_nxt;
    logic slow_r, rev_r, frac_ok_r, sine_mode;
    logic [2:0] sec_prev_r;
    // apb slave with one wait state
    always_comb begin
        cmd_nxt = cmd_r;
        cfg_nxt = cfg_r;
        prdata_nxt = prdata;
        pslverr_nxt = 1'b0;
        pready_nxt = psel & penable & ~pready;
        if (psel & penable & ~pready) begin
            prdata_nxt = 32'h00000000;
            case (paddr)
                `BSC_OFS_CMD: prdata_nxt = cmd_r;
                `BSC_OFS_CFG: prdata_nxt = cfg_r;
                `BSC_OFS_STAT: prdata_nxt = stat_w;
                default: pslverr_nxt = 1'b1;
            endcase
        end
        if (psel & penable & pready & pwrite) begin
            case (paddr)
                `BSC_OFS_CMD: cmd_nxt = pwdata & `BSC_CMD_MASK;
                `BSC_OFS_CFG: cfg_nxt = pwdata & `BSC_CFG_MASK;
                default: cmd_nxt = cmd_r;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= `BSC_CMD_RST;
            cfg_r <= `BSC_CFG_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            cfg_r <= cfg_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end
    // field decode and status word
    assign range = cmd_r[`BSC_CMD_RANGE];
    assign cmd_duty = cmd_r[`BSC_CMD_DUTY];
    assign mode_b = cmd_r[`BSC_CMD_MODE_B];
    assign cmd_dir = cmd_r[`BSC_CMD_DIR];
    assign pulse_sel = cfg_r[`BSC_CFG_PULSE];
    assign sine_sel = cfg_r[`BSC_CFG_SINE];
    always_comb begin
        stat_w = 32'h00000000;
        stat_w[`BSC_ST_SECTOR] = sec_prev_r;
        stat_w[`BSC_ST_STATE] = state_r;
        stat_w[`BSC_ST_SINE] = sine_mode;
        stat_w[`BSC_ST_SLOW] = slow_r;
        stat_w[`BSC_ST_REV] = rev_r;
        stat_w[`BSC_ST_FRAC] = frac_ok_r;
    end

    // ==========================================
    // speed measurement on U period
    logic [23:0] u_cnt_r, u_cnt_nxt;
    logic slow_nxt, frac_ok_nxt, seen_r, seen_nxt, u_rise;
    assign u_rise = hall[2] & ~hall_prev_r[2];
    always_comb begin
        u_cnt_nxt = sat_inc(u_cnt_r);
        seen_nxt = seen_r;
        slow_nxt = slow_r | (u_cnt_r > SLOW_LIMIT);
        frac_ok_nxt = frac_ok_r & (u_cnt_r <= FRAC_LIMIT);
        if (u_rise) begin
            u_cnt_nxt = 24'h000000;
            seen_nxt = 1'b1;
            slow_nxt = ~seen_r | (u_cnt_r > SLOW_LIMIT);
            frac_ok_nxt = seen_r & (u_cnt_r <= FRAC_LIMIT);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            u_cnt_r <= 24'h000000;
            seen_r <= 1'b0;
            slow_r <= 1'b1;
            frac_ok_r <= 1'b0;
        end else begin
            u_cnt_r <= u_cnt_nxt;
            seen_r <= seen_nxt;
            slow_r <= slow_nxt;
            frac_ok_r <= frac_ok_nxt;
        end
    end
    assign sine_mode = ~slow_r & ~rev_r;
    assign lead_off = (sine_mode & (range != `BSC_RNG_TEST))
        ? 8'(({3'h0, cfg_r[`BSC_CFG_LEAD]} * 8'h04) / 8'h03) : 8'h00;

    // ==========================================
    // rotor angle estimate between hall edges
    logic [2:0] sector, lsec, sec_prev_nxt;
    logic [23:0] sec_cnt_r, sec_cnt_nxt, sec_per_r, sec_per_nxt, acc_r, acc_nxt, acc_sum;
    logic [7:0] angle_r, angle_nxt, left_r, left_nxt;
    logic rev_nxt, ang_step, resync60;
    assign sector = hall_sector(hall);
    assign lsec = (cmd_dir && sector != 3'h0) ? 3'h6 - sector : sector;
    assign resync60 = (sine_sel == `BSC_SINE_60A) || (sine_sel == `BSC_SINE_60B)
        || (range == `BSC_RNG_TEST);
    always_comb begin
        sec_cnt_nxt = sat_inc(sec_cnt_r);
        sec_per_nxt = sec_per_r;
        sec_prev_nxt = sec_prev_r;
        rev_nxt = rev_r;
        angle_nxt = angle_r;
        left_nxt = left_r;
        acc_nxt = acc_r;
        ang_step = 1'b0;
        acc_sum = acc_r + {16'h0000, `BSC_ANG_PER_SEC};
        if (sector != `BSC_SEC_BAD && sector != sec_prev_r) begin
            sec_prev_nxt = sector;
            sec_per_nxt = sec_cnt_r;
            sec_cnt_nxt = 24'h000000;
            acc_nxt = 24'h000000;
            left_nxt = `BSC_ANG_PER_SEC;
            if (sec_prev_r != `BSC_SEC_BAD) begin
                rev_nxt = (sector == sec_step(sec_prev_r, cmd_dir));
            end
            if (resync60 || lsec == 3'h0) begin
                angle_nxt = 8'(lsec * `BSC_ANG_PER_SEC) + lead_off;
            end
        end else if (left_r != 8'h00) begin
            acc_nxt = acc_sum;
            if (acc_sum >= sec_per_r) begin
                acc_nxt = acc_sum - sec_per_r;
                angle_nxt = angle_r + 8'h01;
                left_nxt = left_r - 8'h01;
                ang_step = 1'b1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt_r <= 24'h000000;
            sec_per_r <= 24'hFFFFFF;
            sec_prev_r <= `BSC_SEC_BAD;
            rev_r <= 1'b0;
            angle_r <= 8'h00;
            left_r <= 8'h00;
            acc_r <= 24'h000000;
        end else begin
            sec_cnt_r <= sec_cnt_nxt;
            sec_per_r <= sec_per_nxt;
            sec_prev_r <= sec_prev_nxt;
            rev_r <= rev_nxt;
            angle_r <= angle_nxt;
            left_r <= left_nxt;
            acc_r <= acc_nxt;
        end
    end

    // ==========================================
    // drive state: idle, refresh before start, drive
    logic [18:0] ref_cnt_r, ref_cnt_nxt;
    logic drive_rng, refresh_rng;
    assign drive_rng = mode_b ? (range != `BSC_RNG_LOW) : (range == `BSC_RNG_NORMAL || range == `BSC_RNG_TEST);
    assign refresh_rng = mode_b ? (range == `BSC_RNG_LOW) : (range == `BSC_RNG_REFRESH);
    always_comb begin
        state_nxt = state_r;
        ref_cnt_nxt = ref_cnt_r;
        unique case (state_r)
            BSC_ST_IDLE: begin
                ref_cnt_nxt = 19'h00000;
                if (drive_rng) begin
                    state_nxt = slow_r ? BSC_ST_REFRESH : BSC_ST_DRIVE;
                end
            end
            BSC_ST_REFRESH: begin
                ref_cnt_nxt = ref_cnt_r + 19'h00001;
                if (!drive_rng) begin
                    state_nxt = BSC_ST_IDLE;
                end else if (ref_cnt_r == REFRESH_CYC - 19'h00001) begin
                    state_nxt = BSC_ST_DRIVE;
                end
            end
            BSC_ST_DRIVE: begin
                if (!drive_rng) begin
                    state_nxt = BSC_ST_IDLE;
                end
            end
            default: state_nxt = BSC_ST_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= BSC_ST_IDLE;
            ref_cnt_r <= 19'h00000;
        end else begin
            state_r <= state_nxt;
            ref_cnt_r <= ref_cnt_nxt;
        end
    end

    // ==========================================
    // phase requests
    logic [8:0] carrier_cnt, on_sq;
    logic [7:0] eff_duty, ang_v, ang_w;
    bsc_phase_t want_u, want_v, want_w;
    logic [5:0] sq;
    logic in_ref;
    assign eff_duty = (range == `BSC_RNG_TEST || cmd_duty >= `BSC_DUTY_KNEE) ? `BSC_DUTY_MAX : cmd_duty;
    assign on_sq = {eff_duty, 1'b0};
    assign in_ref = carrier_cnt < `BSC_REFRESH_ON;
    assign ang_v = cmd_dir ? angle_r + 8'hAB : angle_r - 8'hAB;
    assign ang_w = cmd_dir ? angle_r - 8'hAB : angle_r + 8'hAB;
    // pwm phase, low phase, floating phase per sector
    always_comb begin
        sq = 6'b000000;
        unique case (sector)
            3'h0: sq = 6'b100100;
            3'h1: sq = 6'b100001;
            3'h2: sq = 6'b001001;
            3'h3: sq = 6'b011000;
            3'h4: sq = 6'b010010;
            3'h5: sq = 6'b000110;
            default: sq = 6'b000000;
        endcase
        if (cmd_dir) begin
            sq = {sq[4], sq[5], sq[2], sq[3], sq[0], sq[1]};
        end
    end
    function automatic bsc_phase_t sq_req(input logic [1:0] code, input logic [8:0] cnt, input logic [8:0] on,
                                         input logic refr);
        if (code == 2'b10) begin
            if (refr) begin
                return BSC_PH_LO;
            end
            return (cnt < on) ? BSC_PH_HI : BSC_PH_OFF;
        end
        return (code == 2'b01) ? BSC_PH_LO : BSC_PH_OFF;
    endfunction
    always_comb begin
        want_u = BSC_PH_OFF;
        want_v = BSC_PH_OFF;
        want_w = BSC_PH_OFF;
        if (state_r == BSC_ST_DRIVE) begin
            if (sine_mode) begin
                want_u = (carrier_cnt < sine_on(angle_r, eff_duty)) ? BSC_PH_HI : BSC_PH_LO;
                want_v = (carrier_cnt < sine_on(ang_v, eff_duty)) ? BSC_PH_HI : BSC_PH_LO;
                want_w = (carrier_cnt < sine_on(ang_w, eff_duty)) ? BSC_PH_HI : BSC_PH_LO;
            end else begin
                want_u = sq_req(sq[5:4], carrier_cnt, on_sq, in_ref);
                want_v = sq_req(sq[3:2], carrier_cnt, on_sq, in_ref);
                want_w = sq_req(sq[1:0], carrier_cnt, on_sq, in_ref);
            end
        end else if ((state_r == BSC_ST_REFRESH || refresh_rng) && in_ref) begin
            want_u = BSC_PH_LO;
            want_v = BSC_PH_LO;
            want_w = BSC_PH_LO;
        end
    end

    bsc_carrier u_carrier (.pclk(pclk), .presetn(presetn), .carrier_cnt(carrier_cnt));
    bsc_dead_time u_dt_u (.pclk(pclk), .presetn(presetn), .want(want_u), .gate_hi(gate_uh), .gate_lo(gate_ul));
    bsc_dead_time u_dt_v (.pclk(pclk), .presetn(presetn), .want(want_v), .gate_hi(gate_vh), .gate_lo(gate_vl));
    bsc_dead_time u_dt_w (.pclk(pclk), .presetn(presetn), .want(want_w), .gate_hi(gate_wh), .gate_lo(gate_wl));

    // ==========================================
    // rotation pulse output
    logic tog_r, tog_nxt, frac_r, frac_nxt, fg_nxt;
    logic [8:0] fg_acc_r, fg_acc_nxt, fg_inc, fg_sum;
    always_comb begin
        unique case (pulse_sel)
            4'h1, 4'h2: fg_inc = `BSC_FG_INC_24;
            4'h3, 4'h4: fg_inc = `BSC_FG_INC_20;
            4'h5, 4'h6: fg_inc = `BSC_FG_INC_08;
            default: fg_inc = 9'h000;
        endcase
        fg_sum = fg_acc_r + fg_inc;
        tog_nxt = tog_r ^ (hall != hall_prev_r);
        fg_acc_nxt = fg_acc_r;
        frac_nxt = frac_r;
        if (!frac_ok_r) begin
            fg_acc_nxt = 9'h000;
            frac_nxt = 1'b0;
        end else if (ang_step) begin
            fg_acc_nxt = fg_sum;
            if (fg_sum >= `BSC_FG_WRAP) begin
                fg_acc_nxt = fg_sum - `BSC_FG_WRAP;
                frac_nxt = ~frac_r;
            end
        end
        if (pulse_sel == `BSC_FG_3P) begin
            fg_nxt = tog_nxt;
        end else if (pulse_sel == `BSC_FG_1P) begin
            fg_nxt = hall[2];
        end else if (pulse_sel == `BSC_FG_LEAD) begin
            fg_nxt = ~angle_r[7];
        end else if (fg_inc != 9'h000) begin
            fg_nxt = frac_nxt;
        end else begin
            fg_nxt = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_r <= 1'b0;
            frac_r <= 1'b0;
            fg_acc_r <= 9'h000;
            rotation_pulse_out <= 1'b0;
        end else begin
            tog_r <= tog_nxt;
            frac_r <= frac_nxt;
            fg_acc_r <= fg_acc_nxt;
            rotation_pulse_out <= fg_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== test/bsc_checker.sv ====
`default_nettype none
// ====
// port checks for the motor controller
module bsc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic gate_uh,
    input wire logic gate_ul,
    input wire logic gate_vh,
    input wire logic gate_vl,
    input wire logic gate_wh,
    input wire logic gate_wl
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus phases
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    // bus answer timing
    a_apb_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready) else $error("wait state wrong");
    a_ready_once: assert property (pready |=> !pready) else $error("ready too long");
    a_err_zero: assert property (pslverr |-> pready && prdata == '0) else $error("error read data");
    // pairs never overlap; gap checked on U high turn-on and V low only
    a_pair_u: assert property (!(gate_uh && gate_ul)) else $error("u overlap");
    a_pair_v: assert property (!(gate_vh && gate_vl)) else $error("v overlap");
    a_pair_w: assert property (!(gate_wh && gate_wl)) else $error("w overlap");
    a_gap_high: assert property ($rose(gate_uh) |-> !$past(gate_ul, 18)) else $error("u gap");
    a_gap_low: assert property ($fell(gate_vh) |=> !gate_vl [*8]) else $error("v gap");
endmodule
`default_nettype wire

// ==== test/bsc_hall_model.sv ====
`default_nettype none
// ====
// hall pairs stepping through six sectors
module bsc_hall_model (
    input wire logic clk,
    input wire logic run,
    input wire logic back,
    input wire logic [11:0] step,
    output logic hall_u_pos,
    output logic hall_u_neg,
    output logic hall_v_pos,
    output logic hall_v_neg,
    output logic hall_w_pos,
    output logic hall_w_neg
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] SEQ = {3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
    logic [2:0] sec = 3'h0;
    logic [11:0] cnt = 12'h000;
    logic [2:0] uvw;
    // one sector per step period, either way round
    always @(posedge clk) begin
        cnt <= (run && cnt < step) ? cnt + 12'h001 : 12'h000;
        if (run && cnt == step) begin
            sec <= back ? (sec == 3'h0 ? 3'h5 : sec - 3'h1) : (sec == 3'h5 ? 3'h0 : sec + 3'h1);
        end
    end
    // clean levels, neg side always the inverse
    assign uvw = SEQ[int'(sec) * 3 +: 3];
    assign hall_u_pos = uvw[2];
    assign hall_u_neg = ~uvw[2];
    assign hall_v_pos = uvw[1];
    assign hall_v_neg = ~uvw[1];
    assign hall_w_pos = uvw[0];
    assign hall_w_neg = ~uvw[0];
endmodule
`default_nettype wire

// ==== test/bsc_top_tb_top.sv ====
`include "bsc_consts.svh"
`default_nettype none
// ====
// bench for the motor controller
module bsc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REF_CYC = 200;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, back, e, prev_fg;
    logic [11:0] paddr, step;
    logic [31:0] pwdata, prdata, q;
    logic hall_u_pos, hall_u_neg, hall_v_pos, hall_v_neg, hall_w_pos, hall_w_neg;
    logic gate_uh, gate_ul, gate_vh, gate_vl, gate_wh, gate_wl, rotation_pulse_out;
    int miscompares, tests_run, rises, lo_on, hi_on, d_rise, d_lo, d_hi;
    logic [3:0] fg_step [7] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9};
    int fg_exp [7] = '{30, 24, 20, 8, 0, 10, 10};
    logic [31:0] cmd_ref [2] = '{32'h00000100, 32'h00001000};
    bsc_top #(.SLOW_LIMIT(24'h0007D0), .FRAC_LIMIT(24'h000BB8), .REFRESH_CYC(19'(REF_CYC))) i_bsc_top (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .hall_u_pos, .hall_u_neg, .hall_v_pos, .hall_v_neg, .hall_w_pos, .hall_w_neg,
        .gate_uh, .gate_ul, .gate_vh, .gate_vl, .gate_wh, .gate_wl, .rotation_pulse_out);
    bsc_hall_model i_bsc_hall_model (.clk(pclk), .run, .back, .step, .hall_u_pos, .hall_u_neg,
        .hall_v_pos, .hall_v_neg, .hall_w_pos, .hall_w_neg);
    // clock, timeout and output counters
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (80000) @(posedge pclk);
        miscompares++;
        conclude();
    end
    always @(posedge pclk) begin
        prev_fg <= rotation_pulse_out;
        rises <= rises + int'(rotation_pulse_out && !prev_fg);
        lo_on <= lo_on + gate_ul + gate_vl + gate_wl;
        hi_on <= hi_on + gate_uh + gate_vh + gate_wh;
    end
    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_near(input int got, input int exp);
        tests_run++;
        if (got < exp - 2 || got > exp + 2) begin
            miscompares++;
            $display("mismatch %0t: count %0d exp %0d", $time, got, exp);
        end
    endtask
    // one bus transfer, held until ready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // output activity over a window of n cycles
    task automatic watch(input int n);
        int r, l, h;
        r = rises;
        l = lo_on;
        h = hi_on;
        repeat (n) @(posedge pclk);
        d_rise = rises - r;
        d_lo = lo_on - l;
        d_hi = hi_on - h;
    endtask
    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, run, back, prev_fg} = '0;
        {rises, lo_on, hi_on, miscompares, tests_run} = '0;
        step = 12'h03B;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `BSC_OFS_STAT, 32'h0);
        chk(q[`BSC_ST_SLOW], 1'b1);
        apb(1'b1, `BSC_OFS_CMD, 32'hFFFFFFFF);
        apb(1'b0, `BSC_OFS_CMD, 32'h0);
        chk(q, `BSC_CMD_MASK);
        apb(1'b0, 12'h00C, 32'h0);
        chk(e, 1'b1);
        // low sides only, 40 of every 512 cycles
        foreach (cmd_ref[i]) begin
            apb(1'b1, `BSC_OFS_CMD, cmd_ref[i]);
            watch(600);
            watch(2048);
            chk(d_lo, 480);
            chk(d_hi, 0);
        end
        apb(1'b1, `BSC_OFS_CMD, 32'h0);
        watch(600);
        watch(1024);
        chk(d_lo + d_hi, 0);
        apb(1'b1, `BSC_OFS_CMD, 32'h00000280);
        apb(1'b0, `BSC_OFS_STAT, 32'h0);
        chk(q[`BSC_ST_STATE], 2'h1);
        watch(REF_CYC + 8);
        apb(1'b0, `BSC_OFS_STAT, 32'h0);
        chk(q[`BSC_ST_STATE], 2'h3);
        run <= 1'b1;
        watch(1500);
        apb(1'b0, `BSC_OFS_STAT, 32'h0);
        chk(q[`BSC_ST_SINE], 1'b1);
        chk(q[`BSC_ST_REV], 1'b0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `BSC_OFS_CFG, {28'h0, fg_step[i]});
            watch(720);
            watch(3600);
            chk_near(d_rise, fg_exp[i]);
        end
        // slow rotation: square drive, fractional pulses stop
        apb(1'b1, `BSC_OFS_CFG, 32'h1);
        step <= 12'h257;
        watch(8000);
        watch(3600);
        chk(d_rise, 0);
        apb(1'b0, `BSC_OFS_STAT, 32'h0);
        chk(q[`BSC_ST_SINE], 1'b0);
        step <= 12'h03B;
        back <= 1'b1;
        watch(1500);
        apb(1'b0, `BSC_OFS_STAT, 32'h0);
        chk(q[`BSC_ST_REV], 1'b1);
        chk(q[`BSC_ST_SINE], 1'b0);
        conclude();
    end
endmodule
bind bsc_top bsc_checker i_bsc_checker (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
    .gate_uh, .gate_ul, .gate_vh, .gate_vl, .gate_wh, .gate_wl);
`default_nettype wire
